// ===== shared/rfb_map.svh
`ifndef RFB_MAP_SVH
`define RFB_MAP_SVH

// ==================================================
// register byte offsets
`define RFB_OFF_MAC_CTRL    8'h00
`define RFB_OFF_LOW_THRESH  8'h04
`define RFB_OFF_FLOW_BASE   8'h20
`define RFB_OFF_FREE_BASE   8'h40

// ==================================================
// field positions and masks
`define RFB_PAUSE_EN_BIT    12
`define RFB_MAC_CTRL_MASK   32'h0007FAFB
`define RFB_LEVEL_MSB       7
`define RFB_COUNT_MSB       15

// ==================================================
// reset values and sizes
`define RFB_RESET_WORD      32'h00000000
`define RFB_NUM_CHAN        8

`endif

// ===== shared/rfb_pkg.sv
package rfb_pkg;

  typedef logic [15:0] rfb_count_t;
  typedef logic [7:0]  rfb_level_t;

  // per channel state
  typedef struct packed {
    rfb_count_t count;
    logic       dropLow;
    logic       flowOn;
  } rfb_chan_s;

  // register file and bus state
  typedef struct packed {
    logic                  waitReq;
    logic [31:0]           readData;
    logic [31:0]           macCtrl;
    rfb_level_t            lowLevel;
    logic [7:0][7:0]       flowLevel;
  } rfb_regs_s;

endpackage

// ===== shared/rfb_chan_if.sv
interface rfb_chan_if;
  logic                addEn;
  rfb_pkg::rfb_count_t addVal;
  logic                subEn;
  rfb_pkg::rfb_count_t subVal;
  rfb_pkg::rfb_level_t filterLevel;
  rfb_pkg::rfb_level_t flowLevel;
  logic                flowEn;
  rfb_pkg::rfb_count_t count;
  logic                dropLow;
  logic                flowOn;

  modport ctrl (
    output addEn, addVal, subEn, subVal, filterLevel, flowLevel, flowEn,
    input  count, dropLow, flowOn
  );
  modport chan (
    input  addEn, addVal, subEn, subVal, filterLevel, flowLevel, flowEn,
    output count, dropLow, flowOn
  );
endinterface

// ===== core/rfb_chan_count.sv
`include "rfb_map.svh"

module rfb_chan_count (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clkEn,
  rfb_chan_if.chan io
);

  rfb_pkg::rfb_chan_s  st_q;
  rfb_pkg::rfb_chan_s  st_d;
  rfb_pkg::rfb_count_t nextCount;

  // ==================================================
  // count update and threshold compare
  always_comb begin
    nextCount = st_q.count;
    if (io.addEn) begin
      nextCount = rfb_pkg::rfb_count_t'(nextCount + io.addVal);
    end
    if (io.subEn) begin
      nextCount = rfb_pkg::rfb_count_t'(nextCount - io.subVal);
    end
    st_d         = st_q;
    st_d.count   = nextCount;
    st_d.dropLow = (io.filterLevel != 8'h00) && (nextCount < {8'h00, io.filterLevel});
    st_d.flowOn  = io.flowEn && (io.flowLevel != 8'h00)
                   && (nextCount < {8'h00, io.flowLevel});
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else if (clkEn) begin
      st_q <= st_d;
    end
  end

  assign io.count   = st_q.count;
  assign io.dropLow = st_q.dropLow;
  assign io.flowOn  = st_q.flowOn;

  // ==================================================
  // checks
  count_add_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && io.addEn && !io.subEn |=> io.count == rfb_pkg::rfb_count_t'($past(io.count) + $past(io.addVal)))
    else $error("free count did not add written value");

  count_sub_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && io.subEn && !io.addEn |=> io.count == rfb_pkg::rfb_count_t'($past(io.count) - $past(io.subVal)))
    else $error("free count did not drop by frame buffers");

  count_wrap_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && io.addEn && !io.subEn && io.count == 16'hFFFF && io.addVal == 16'h0001 |=> io.count == 16'h0000)
    else $error("free count did not wrap to zero");

  zero_filter_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && io.filterLevel == 8'h00 |=> !io.dropLow)
    else $error("drop raised with zero filter level");

  drop_level_a: assert property (@(posedge mclk) disable iff (!rst_n)
    io.dropLow && $stable(io.filterLevel) |-> io.count < {8'h00, io.filterLevel})
    else $error("drop raised with count not below level");

  flow_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && !io.flowEn |=> !io.flowOn)
    else $error("flow control raised while disabled");

  flow_level_a: assert property (@(posedge mclk) disable iff (!rst_n)
    io.flowOn && $stable(io.flowLevel) |-> io.flowLevel != 8'h00 && io.count < {8'h00, io.flowLevel})
    else $error("flow control raised with count not below level");

endmodule

// ===== core/rfb_free_buffer_acct.sv
// Chosen here: the Avalon-MM register port and the register offsets.
`include "rfb_map.svh"

module rfb_free_buffer_acct (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        clkEn,
  input  wire logic [7:0]  avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [3:0]  avsByteenable,
  input  wire logic [31:0] avsWritedata,
  output logic      [31:0] avsReaddata,
  output logic             avsWaitrequest,
  input  wire logic        frameDone,
  input  wire logic [2:0]  frameChan,
  input  wire logic [15:0] frameBufs,
  output logic      [7:0]  lowPrioDrop,
  output logic      [7:0]  flowCtrlAssert
);

  localparam logic [7:0] MacCtrlOff   = `RFB_OFF_MAC_CTRL;
  localparam logic [7:0] LowThreshOff = `RFB_OFF_LOW_THRESH;
  localparam logic [7:0] FlowBase     = `RFB_OFF_FLOW_BASE;
  localparam logic [7:0] FreeBase     = `RFB_OFF_FREE_BASE;

  rfb_pkg::rfb_regs_s  st_q;
  rfb_pkg::rfb_regs_s  st_d;
  rfb_pkg::rfb_count_t chanCount [`RFB_NUM_CHAN];
  logic [7:0]          chanDrop;
  logic [7:0]          chanFlow;
  logic [7:0]          chanAdd;
  rfb_pkg::rfb_count_t addVal;
  logic                busReq;
  logic                accept;
  logic                inFlow;
  logic                inFree;
  logic [2:0]          chanSel;
  logic [31:0]         readMux;

  rfb_chan_if chanIf [`RFB_NUM_CHAN] ();

  // ==================================================
  // address decode
  assign busReq  = avsRead || avsWrite;
  assign accept  = busReq && !st_q.waitReq;
  assign chanSel = avsAddress[4:2];
  assign inFlow  = (avsAddress[7:5] == FlowBase[7:5]) && (avsAddress[1:0] == 2'h0);
  assign inFree  = (avsAddress[7:5] == FreeBase[7:5]) && (avsAddress[1:0] == 2'h0);
  assign addVal  = {avsByteenable[1] ? avsWritedata[15:8] : 8'h00,
                    avsByteenable[0] ? avsWritedata[7:0] : 8'h00};

  always_comb begin
    readMux = `RFB_RESET_WORD;
    if (avsAddress == MacCtrlOff) begin
      readMux = st_q.macCtrl;
    end else if (avsAddress == LowThreshOff) begin
      readMux = {24'h000000, st_q.lowLevel};
    end else if (inFlow) begin
      readMux = {24'h000000, st_q.flowLevel[chanSel]};
    end else if (inFree) begin
      readMux = {16'h0000, chanCount[chanSel]};
    end
  end

  // ==================================================
  // bus and register state
  always_comb begin
    st_d    = st_q;
    chanAdd = 8'h00;
    if (accept) begin
      st_d.waitReq = 1'b1;
      if (avsWrite) begin
        if (avsAddress == MacCtrlOff) begin
          for (int b = 0; b < 4; b++) begin
            if (avsByteenable[b]) begin
              st_d.macCtrl[b*8 +: 8] = 8'((avsWritedata & `RFB_MAC_CTRL_MASK) >> (b*8));
            end
          end
        end else if (avsAddress == LowThreshOff && avsByteenable[0]) begin
          st_d.lowLevel = avsWritedata[7:0];
        end else if (inFlow && avsByteenable[0]) begin
          st_d.flowLevel[chanSel] = avsWritedata[7:0];
        end else if (inFree) begin
          chanAdd[chanSel] = 1'b1;
        end
      end
    end else if (busReq) begin
      st_d.waitReq  = 1'b0;
      st_d.readData = readMux;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q         <= '0;
      st_q.waitReq <= 1'b1;
    end else if (clkEn) begin
      st_q <= st_d;
    end
  end

  // ==================================================
  // channel counters
  for (genvar g = 0; g < `RFB_NUM_CHAN; g++) begin : gChan
    assign chanIf[g].addEn       = chanAdd[g];
    assign chanIf[g].addVal      = addVal;
    assign chanIf[g].subEn       = frameDone && (frameChan == 3'(g));
    assign chanIf[g].subVal      = frameBufs;
    assign chanIf[g].filterLevel = st_q.lowLevel;
    assign chanIf[g].flowLevel   = st_q.flowLevel[g];
    assign chanIf[g].flowEn      = st_q.macCtrl[`RFB_PAUSE_EN_BIT];
    assign chanCount[g]          = chanIf[g].count;
    assign chanDrop[g]           = chanIf[g].dropLow;
    assign chanFlow[g]           = chanIf[g].flowOn;

    rfb_chan_count uChan (
      .mclk  (mclk),
      .rst_n (rst_n),
      .clkEn (clkEn),
      .io    (chanIf[g])
    );
  end

  assign avsReaddata    = st_q.readData;
  assign avsWaitrequest = st_q.waitReq;
  assign lowPrioDrop    = chanDrop;
  assign flowCtrlAssert = chanFlow;

  // ==================================================
  // checks
  wait_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && !avsWaitrequest |=> avsWaitrequest)
    else $error("waitrequest low for more than one cycle");

  req_answer_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && busReq && avsWaitrequest |=> !avsWaitrequest)
    else $error("request not answered next cycle");

  low_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && accept && avsWrite && avsAddress == LowThreshOff && avsByteenable[0]
    |=> st_q.lowLevel == $past(avsWritedata[7:0]))
    else $error("filter level write lost");

  flow_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && accept && avsWrite && inFlow && avsByteenable[0]
    |=> st_q.flowLevel[$past(chanSel)] == $past(avsWritedata[7:0]))
    else $error("flow level write lost");

  pause_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && !st_q.macCtrl[`RFB_PAUSE_EN_BIT] ##1 !st_q.macCtrl[`RFB_PAUSE_EN_BIT] |-> flowCtrlAssert == 8'h00)
    else $error("flow control out while pause disabled");

  freeze_wait_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !clkEn
    |=> $stable(avsWaitrequest))
    else $error("waitrequest moved while clock enable low");

  freeze_rdata_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !clkEn
    |=> $stable(avsReaddata))
    else $error("read data moved while clock enable low");

  freeze_drop_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !clkEn
    |=> $stable(lowPrioDrop))
    else $error("drop outputs moved while clock enable low");

  freeze_flow_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !clkEn
    |=> $stable(flowCtrlAssert))
    else $error("flow outputs moved while clock enable low");

  freeze_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !clkEn
    |=> $stable(st_q.lowLevel))
    else $error("filter level moved while clock enable low");

  freeze_ctrl_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !clkEn
    |=> $stable(st_q.macCtrl))
    else $error("control moved while clock enable low");

  freeze_count_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !clkEn
    |=> $stable(chanCount[7]))
    else $error("free count moved while clock enable low");

  rdata_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && !(busReq && avsWaitrequest)
    |=> $stable(avsReaddata))
    else $error("read data changed outside an answer");

  read_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && busReq && avsWaitrequest && avsAddress == LowThreshOff
    |=> avsReaddata == {24'h000000, $past(st_q.lowLevel)})
    else $error("filter level read wrong");

  read_flow_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && busReq && avsWaitrequest && inFlow
    |=> avsReaddata == {24'h000000, $past(st_q.flowLevel[chanSel])})
    else $error("flow level read wrong");

  read_free_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && busReq && avsWaitrequest && inFree
    |=> avsReaddata == {16'h0000, $past(chanCount[chanSel])})
    else $error("free count read wrong");

  read_ctrl_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && busReq && avsWaitrequest && avsAddress == MacCtrlOff
    |=> avsReaddata == $past(st_q.macCtrl))
    else $error("control read wrong");

  read_hole_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && busReq && avsWaitrequest && avsAddress != MacCtrlOff && avsAddress != LowThreshOff && !inFlow && !inFree
    |=> avsReaddata == 32'h00000000)
    else $error("unmapped read not zero");

  read_top_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn
    |=> avsReaddata[31:19] == 13'h0000)
    else $error("reserved read bits not zero");

  ctrl_rsvd_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn
    |=> (st_q.macCtrl & ~(`RFB_MAC_CTRL_MASK)) == 32'h00000000)
    else $error("reserved control bits set");

  ctrl_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && accept && avsWrite && avsAddress == MacCtrlOff && avsByteenable == 4'hF
    |=> st_q.macCtrl == ($past(avsWritedata) & `RFB_MAC_CTRL_MASK))
    else $error("control write lost");

  low_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && !(accept && avsWrite && avsAddress == LowThreshOff)
    |=> $stable(st_q.lowLevel))
    else $error("filter level changed without write");

  ctrl_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && !(accept && avsWrite && avsAddress == MacCtrlOff)
    |=> $stable(st_q.macCtrl))
    else $error("control changed without write");

  low_lane_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && accept && avsWrite && avsAddress == LowThreshOff && !avsByteenable[0]
    |=> $stable(st_q.lowLevel))
    else $error("filter level written with lane off");

  early_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && avsWrite && avsWaitrequest
    |=> $stable(st_q.lowLevel) && $stable(st_q.macCtrl) && $stable(st_q.flowLevel))
    else $error("write landed before waitrequest low");

  drop_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && st_q.lowLevel == 8'h00
    |=> lowPrioDrop == 8'h00)
    else $error("drop raised with zero filter level");

  flow_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && st_q.flowLevel[0] == 8'h00
    |=> !flowCtrlAssert[0])
    else $error("flow raised with zero flow level");

  flow_en_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && !st_q.macCtrl[`RFB_PAUSE_EN_BIT]
    |=> flowCtrlAssert == 8'h00)
    else $error("flow raised with pause enable clear");

  add_onehot_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn
    |-> $onehot0(chanAdd))
    else $error("write adds to more than one channel");

  add_source_a: assert property (@(posedge mclk) disable iff (!rst_n)
    chanAdd != 8'h00
    |-> accept && avsWrite && inFree)
    else $error("count add without count write");

  free_add_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && accept && avsWrite && inFree && !(frameDone && frameChan == chanSel)
    |=> chanCount[$past(chanSel)] == 16'($past(chanCount[chanSel]) + $past(addVal)))
    else $error("count write did not add");

  frame_sub_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && frameDone && !chanAdd[frameChan]
    |=> chanCount[$past(frameChan)] == 16'($past(chanCount[frameChan]) - $past(frameBufs)))
    else $error("frame did not subtract buffers");

  add_sub_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && frameDone && chanAdd[frameChan]
    |=> chanCount[$past(frameChan)] == 16'($past(chanCount[frameChan]) + $past(addVal) - $past(frameBufs)))
    else $error("same cycle add and subtract wrong");

  chan_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && !chanAdd[0] && !(frameDone && frameChan == 3'h0)
    |=> $stable(chanCount[0]))
    else $error("idle channel count changed");

endmodule

// ===== test/rfb_free_buffer_acct_tb_top.sv
`include "rfb_map.svh"

module rfb_free_buffer_acct_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [7:0]  addr;
    logic [31:0] wr;
    logic [31:0] rd;
  } rfb_row_s;

  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        clkEn = 1'b1;
  logic [7:0]  avsAddress = 8'h00;
  logic        avsRead = 1'b0;
  logic        avsWrite = 1'b0;
  logic [3:0]  avsByteenable = 4'hF;
  logic [31:0] avsWritedata = 32'h0;
  logic [31:0] avsReaddata;
  logic        avsWaitrequest;
  logic        frameDone = 1'b0;
  logic [2:0]  frameChan = 3'h0;
  logic [15:0] frameBufs = 16'h0;
  logic [7:0]  lowPrioDrop;
  logic [7:0]  flowCtrlAssert;
  logic [31:0] q;
  int          bad_count = 0;
  int          n_tests = 0;
  rfb_row_s    rows[6];

  always #2.5 mclk = ~mclk;

  rfb_free_buffer_acct rfb_free_buffer_acct_i (
    .mclk(mclk), .rst_n(rst_n), .clkEn(clkEn), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsByteenable(avsByteenable), .avsWritedata(avsWritedata),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .frameDone(frameDone),
    .frameChan(frameChan), .frameBufs(frameBufs), .lowPrioDrop(lowPrioDrop),
    .flowCtrlAssert(flowCtrlAssert)
  );

  // ==================================================
  // reporting
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask

  // ==================================================
  // bus master: hold until waitrequest sampled low
  task automatic busCyc(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    avsAddress <= a;
    avsWrite <= w;
    avsRead <= !w;
    avsWritedata <= d;
    do begin
      @(posedge mclk);
      k++;
    end while (avsWaitrequest !== 1'b0 && k < 50);
    if (k >= 50) begin
      $display("[ERR] bus timeout expected 0 seen 1");
      bad_count++;
      stop_test();
    end
    q = avsReaddata;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rdChk(input string n, input logic [7:0] a, input logic [31:0] e);
    busCyc(a, 1'b0, 32'h0);
    chk(n, e, q);
  endtask

  task automatic outChk(input logic [7:0] drop, input logic [7:0] flow);
    repeat (2) @(posedge mclk);
    chk("lowPrioDrop", {24'h0, drop}, {24'h0, lowPrioDrop});
    chk("flowCtrlAssert", {24'h0, flow}, {24'h0, flowCtrlAssert});
  endtask

  // ==================================================
  // main sequence
  initial begin
    rows[0] = '{`RFB_OFF_LOW_THRESH, 32'hFFFFFFFF, 32'h000000FF};
    rows[1] = '{`RFB_OFF_FLOW_BASE + 8'h0C, 32'h123456A5, 32'h000000A5};
    rows[2] = '{`RFB_OFF_MAC_CTRL, 32'hFFFFFFFF, `RFB_MAC_CTRL_MASK};
    rows[3] = '{8'h10, 32'hFFFFFFFF, 32'h00000000};
    rows[4] = '{`RFB_OFF_FREE_BASE + 8'h14, 32'h00030010, 32'h00000010};
    rows[5] = '{`RFB_OFF_FREE_BASE + 8'h14, 32'h00000005, 32'h00000015};
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rdChk("macCtrl reset", `RFB_OFF_MAC_CTRL, `RFB_RESET_WORD);
    rdChk("lowLevel reset", `RFB_OFF_LOW_THRESH, `RFB_RESET_WORD);
    for (int n = 0; n < `RFB_NUM_CHAN; n++) begin
      rdChk("flow reset", `RFB_OFF_FLOW_BASE + 8'(4 * n), `RFB_RESET_WORD);
      rdChk("count reset", `RFB_OFF_FREE_BASE + 8'(4 * n), `RFB_RESET_WORD);
    end
    outChk(8'h00, 8'h00);
    foreach (rows[i]) begin
      busCyc(rows[i].addr, 1'b1, rows[i].wr);
      rdChk("row readback", rows[i].addr, rows[i].rd);
    end
    // wrap past the top of the count
    busCyc(`RFB_OFF_FREE_BASE, 1'b1, 32'h0000FFFF);
    busCyc(`RFB_OFF_FREE_BASE, 1'b1, 32'h00000002);
    rdChk("count wrap", `RFB_OFF_FREE_BASE, 32'h00000001);
    // back-to-back frames on channel 5
    frameDone <= 1'b1;
    frameChan <= 3'h5;
    frameBufs <= 16'h0001;
    @(posedge mclk);
    frameBufs <= 16'h0002;
    @(posedge mclk);
    frameDone <= 1'b0;
    @(posedge mclk);
    rdChk("count after frames", `RFB_OFF_FREE_BASE + 8'h14, 32'h00000012);
    // counts: ch0 1, ch5 0x12, others 0; flow level ch3 0xA5
    busCyc(`RFB_OFF_LOW_THRESH, 1'b1, 32'h00000020);
    outChk(8'hFF, 8'h08);
    busCyc(`RFB_OFF_LOW_THRESH, 1'b1, 32'h00000012);
    outChk(8'hDF, 8'h08);
    busCyc(`RFB_OFF_LOW_THRESH, 1'b1, 32'h00000000);
    outChk(8'h00, 8'h08);
    busCyc(`RFB_OFF_MAC_CTRL, 1'b1, 32'h00000000);
    outChk(8'h00, 8'h00);
    // clock enable low freezes a frame on ch0
    clkEn <= 1'b0;
    frameDone <= 1'b1;
    frameChan <= 3'h0;
    frameBufs <= 16'h0001;
    repeat (3) @(posedge mclk);
    frameDone <= 1'b0;
    clkEn <= 1'b1;
    @(posedge mclk);
    rdChk("count frozen", `RFB_OFF_FREE_BASE, 32'h00000001);
    // frames on ch5 during a count write: 3 subtracts and one add
    frameDone <= 1'b1;
    frameChan <= 3'h5;
    busCyc(`RFB_OFF_FREE_BASE + 8'h14, 1'b1, 32'h00000010);
    frameDone <= 1'b0;
    rdChk("add with frames", `RFB_OFF_FREE_BASE + 8'h14, 32'h0000001F);
    // only lane 0 adds
    avsByteenable <= 4'h1;
    busCyc(`RFB_OFF_FREE_BASE + 8'h14, 1'b1, 32'h00000203);
    avsByteenable <= 4'hF;
    rdChk("lane add", `RFB_OFF_FREE_BASE + 8'h14, 32'h00000022);
    stop_test();
  end
endmodule
